// ===== hw/baud_pkg.sv
// baud_pkg: register map, field layout, reset values and widths of the
// baud rate block.
// assumes a 32-bit AXI4-Lite register bus with word-aligned registers.
package baud_pkg;

    // ------------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------------
    localparam logic [4:0] OFS_DIV_HIGH = 5'h00; // baud_divisor_high
    localparam logic [4:0] OFS_DIV_LOW  = 5'h04; // baud_divisor_low
    localparam logic [4:0] OFS_CTRL     = 5'h08; // ctrl_reg_two stand-in
    localparam logic [4:0] OFS_SYSOPT   = 5'h0C; // system_option_register
    localparam logic [4:0] OFS_IRQ_STAT = 5'h10; // sticky flags, write one to clear
    localparam logic [4:0] OFS_IRQ_MASK = 5'h14; // same layout as the flags
    localparam logic [4:0] OFS_STATUS   = 5'h18; // working divisor and run state

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int DIV_WIDTH      = 13;
    localparam int DIV_HIGH_BITS  = 5;
    localparam int BIT_BREAK_IE   = 7;  // in baud_divisor_high
    localparam int BIT_EDGE_IE    = 6;  // in baud_divisor_high
    localparam int BIT_TX_ON      = 0;  // in control register
    localparam int BIT_RX_ON      = 1;  // in control register
    localparam int BIT_POS_SEL    = 0;  // in system option register
    localparam int FLAG_BREAK     = 0;  // in flags and mask
    localparam int FLAG_EDGE      = 1;  // in flags and mask
    localparam int BIT_RUN_STATUS = 16; // in status register

    // ------------------------------------------------------------------
    // reset values and constants
    // ------------------------------------------------------------------
    localparam logic [4:0]  DIV_HIGH_RESET = 5'h00;
    localparam logic [7:0]  DIV_LOW_RESET  = 8'h04; // any non-zero value
    localparam int          OVERSAMPLE     = 16;
    localparam logic [1:0]  RESP_OKAY      = 2'h0;
    localparam logic [1:0]  RESP_SLVERR    = 2'h2;
    localparam int          SYS_CLK_HZ     = 10_000_000;

endpackage : baud_pkg

// ===== hw/baud_if.sv
// baud_if: divisor and run level toward the generator, ticks back.
// assumes both ends share sys_clk.
`timescale 1ns/1ps
interface baud_if;
    logic [12:0] divisor;  // working 13-bit modulo divisor
    logic        run;      // generator allowed to count
    logic        tick16;   // one pulse per oversample period
    logic        bitTick;  // one pulse per bit period

    modport ctrl (output divisor, output run, input tick16, input bitTick);
    modport gen  (input divisor, input run, output tick16, output bitTick);
endinterface : baud_if

// ===== hw/sync_two_ff.sv
// sync_two_ff: two flip-flop synchroniser for pin levels.
// assumes inputs are asynchronous levels; only the second stage is read.
`timescale 1ns/1ps
module sync_two_ff #(
    parameter int WIDTH = 2
) (
    // clock and reset
    input  wire logic             sys_clk,
    input  wire logic             reset_n,
    // levels
    input  wire logic [WIDTH-1:0] asyncIn,
    output logic      [WIDTH-1:0] syncOut
);
    logic [WIDTH-1:0] stage1_reg;

    // first stage feeds the second and nothing else
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            stage1_reg <= '1; // idle line level
            syncOut    <= '1;
        end else begin
            stage1_reg <= asyncIn;
            syncOut    <= stage1_reg;
        end
    end
endmodule : sync_two_ff

// ===== hw/baud_generator.sv
// baud_generator: modulo prescaler followed by a divide-by-sixteen.
// assumes the divisor only changes through the register block.
`timescale 1ns/1ps
module baud_generator
    import baud_pkg::*;
(
    // clock and reset
    input  wire logic sys_clk,
    input  wire logic reset_n,
    // configuration and ticks
    baud_if.gen       bus
);
    logic [12:0] preCount_reg;
    logic [3:0]  phase_reg;

    // prescaler: counts are held at zero while stopped so nothing toggles
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            preCount_reg <= 13'h0000;
            bus.tick16   <= 1'b0;
        end else if (!bus.run) begin
            preCount_reg <= 13'h0000;
            bus.tick16   <= 1'b0;
        end else if (preCount_reg >= bus.divisor - 13'h0001) begin
            preCount_reg <= 13'h0000;
            bus.tick16   <= 1'b1;
        end else begin
            preCount_reg <= preCount_reg + 13'h0001;
            bus.tick16   <= 1'b0;
        end
    end

    // sixteen oversample ticks make one bit period
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            phase_reg   <= 4'h0;
            bus.bitTick <= 1'b0;
        end else if (!bus.run) begin
            phase_reg   <= 4'h0;
            bus.bitTick <= 1'b0;
        end else begin
            bus.bitTick <= bus.tick16 && (phase_reg == 4'(OVERSAMPLE - 1));
            if (bus.tick16) begin
                phase_reg <= phase_reg + 4'h1;
            end
        end
    end
endmodule : baud_generator

// ===== hw/baud_rate_block.sv
// baud_rate_block: baud divisor registers, pin position select and the
// break and receive-edge interrupt requests, behind an AXI4-Lite slave.
// assumes event inputs are one-cycle pulses on sys_clk and pins are async.
//
// Overview of operation
// - position select 0 routes the second tx/rx pair to the default pins, 1 to the alternate.
// - the high divisor write is buffered and the 13-bit divisor updates on the low write.
// - the generator stays off after reset until rx_on or tx_on is first written to one.
// - a divisor of zero stops the generator completely.
// - divisors 1 to 8191 give a bit rate of the bus clock over sixteen times the divisor.
// - high register bit 7 lets the break flag raise an interrupt request.
// - high register bit 6 lets the receive-edge flag raise an interrupt request.
// - divisor bits 12:8 sit in high bits 4:0 and bits 7:0 in low bits 7:0.
//
// Implementation choices: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module baud_rate_block
    import baud_pkg::*;
(
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        reset_n,
    // axi4-lite write address and data
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_awaddr,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    // axi4-lite write response
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    output logic [1:0]       s_axi_bresp,
    // axi4-lite read
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    input  wire logic [31:0] s_axi_araddr,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    // events from the receiver
    input  wire logic        breakDetectEvent,
    input  wire logic        rxEdgeEvent,
    // serial data to and from the transmitter and receiver
    input  wire logic        secondTxData,
    output logic             secondRxData,
    // port pins
    output logic             txPinDefault,
    output logic             txPinDefaultOe,
    output logic             txPinAlt,
    output logic             txPinAltOe,
    input  wire logic        rxPinDefault,
    input  wire logic        rxPinAlt,
    // baud timing
    output logic             baudTick16,
    output logic             bitTick,
    output logic             generatorActive,
    // interrupt requests
    output logic             breakIrq,
    output logic             edgeIrq,
    output logic             irq
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    logic [4:0]  divHighBuf_reg;   // buffered high half
    logic [4:0]  divHighWork_reg;  // working high half
    logic [7:0]  divLow_reg;
    logic        breakIe_reg;
    logic        edgeIe_reg;
    logic        txOn_reg;
    logic        rxOn_reg;
    logic        armed_reg;
    logic        posSel_reg;
    logic [1:0]  flags_reg;
    logic        awHave_reg;
    logic        wHave_reg;
    logic [4:0]  awAddr_reg;
    logic [31:0] wData_reg;
    logic [3:0]  wStrb_reg;
    logic [1:0]  rxPinsSync;
    logic        doWrite;
    logic [12:0] divisor;
    logic [1:0]  flagHits;
    logic [1:0]  irqMask;

    baud_if baudLink ();

    // word address decode shared by the read and write paths
    function automatic logic mapped(input logic [4:0] a);
        return a == OFS_DIV_HIGH || a == OFS_DIV_LOW || a == OFS_CTRL
            || a == OFS_SYSOPT || a == OFS_IRQ_STAT || a == OFS_IRQ_MASK
            || a == OFS_STATUS;
    endfunction : mapped

    // ------------------------------------------------------------------
    // write channel: address and data taken in either order
    // ------------------------------------------------------------------
    assign s_axi_awready = !awHave_reg && !s_axi_bvalid;
    assign s_axi_wready  = !wHave_reg && !s_axi_bvalid;
    assign doWrite       = awHave_reg && wHave_reg && !s_axi_bvalid;

    // hold each half until its partner arrives, then answer once
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            awHave_reg   <= 1'b0;
            wHave_reg    <= 1'b0;
            awAddr_reg   <= 5'h00;
            wData_reg    <= 32'h0000_0000;
            wStrb_reg    <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awHave_reg <= 1'b1;
                awAddr_reg <= {s_axi_awaddr[4:2], 2'b00};
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wHave_reg <= 1'b1;
                wData_reg <= s_axi_wdata;
                wStrb_reg <= s_axi_wstrb;
            end
            if (doWrite) begin
                awHave_reg   <= 1'b0;
                wHave_reg    <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= mapped(awAddr_reg) ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // divisor, enables and control
    // ------------------------------------------------------------------
    // registers are 8 bits wide, so only lane 0 matters
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            divHighBuf_reg  <= DIV_HIGH_RESET;
            divHighWork_reg <= DIV_HIGH_RESET;
            divLow_reg      <= DIV_LOW_RESET;
            breakIe_reg     <= 1'b0;
            edgeIe_reg      <= 1'b0;
            txOn_reg        <= 1'b0;
            rxOn_reg        <= 1'b0;
            posSel_reg      <= 1'b0;
        end else if (doWrite && wStrb_reg[0]) begin
            unique case (awAddr_reg)
                OFS_DIV_HIGH: begin
                    divHighBuf_reg <= wData_reg[DIV_HIGH_BITS-1:0];
                    breakIe_reg    <= wData_reg[BIT_BREAK_IE];
                    edgeIe_reg     <= wData_reg[BIT_EDGE_IE];
                end
                OFS_DIV_LOW: begin
                    divHighWork_reg <= divHighBuf_reg;
                    divLow_reg      <= wData_reg[7:0];
                end
                OFS_CTRL: begin
                    txOn_reg <= wData_reg[BIT_TX_ON];
                    rxOn_reg <= wData_reg[BIT_RX_ON];
                end
                OFS_SYSOPT: begin
                    posSel_reg <= wData_reg[BIT_POS_SEL];
                end
                OFS_IRQ_MASK: begin
                    // the mask is another view of the two enables
                    breakIe_reg <= wData_reg[FLAG_BREAK];
                    edgeIe_reg  <= wData_reg[FLAG_EDGE];
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            armed_reg <= 1'b0;
        end else if (doWrite && wStrb_reg[0] && awAddr_reg == OFS_CTRL
                     && (wData_reg[BIT_TX_ON] || wData_reg[BIT_RX_ON])) begin
            armed_reg <= 1'b1;
        end
    end

    assign divisor = {divHighWork_reg, divLow_reg};

    // ------------------------------------------------------------------
    // baud generator
    // ------------------------------------------------------------------
    // zero divisor stops all
    assign baudLink.divisor = divisor;
    assign baudLink.run     = armed_reg && (divisor != 13'h0000);
    assign baudTick16       = baudLink.tick16;
    assign bitTick          = baudLink.bitTick;
    assign generatorActive  = baudLink.run;

    baud_generator u_gen (
        .sys_clk (sys_clk),
        .reset_n (reset_n),
        .bus     (baudLink)
    );

    // ------------------------------------------------------------------
    // pin position select
    // ------------------------------------------------------------------
    sync_two_ff #(.WIDTH(2)) u_rxSync (
        .sys_clk (sys_clk),
        .reset_n (reset_n),
        .asyncIn ({rxPinAlt, rxPinDefault}),
        .syncOut (rxPinsSync)
    );

    // route the pin pair; the unselected tx pin is released
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            txPinDefault   <= 1'b1;
            txPinDefaultOe <= 1'b0;
            txPinAlt       <= 1'b1;
            txPinAltOe     <= 1'b0;
            secondRxData   <= 1'b1;
        end else begin
            txPinDefault   <= secondTxData;
            txPinDefaultOe <= !posSel_reg;
            txPinAlt       <= secondTxData;
            txPinAltOe     <= posSel_reg;
            secondRxData   <= posSel_reg ? rxPinsSync[1] : rxPinsSync[0];
        end
    end

    // ------------------------------------------------------------------
    // flags and interrupt requests
    // ------------------------------------------------------------------
    assign flagHits = {rxEdgeEvent, breakDetectEvent};

    // a new event wins over a clear in the same cycle
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            flags_reg <= 2'b00;
        end else if (doWrite && wStrb_reg[0] && awAddr_reg == OFS_IRQ_STAT) begin
            flags_reg <= (flags_reg & ~wData_reg[1:0]) | flagHits;
        end else begin
            flags_reg <= flags_reg | flagHits;
        end
    end

    assign irqMask = {edgeIe_reg, breakIe_reg};
    assign breakIrq = flags_reg[FLAG_BREAK] && irqMask[FLAG_BREAK];
    assign edgeIrq  = flags_reg[FLAG_EDGE] && irqMask[FLAG_EDGE];
    assign irq      = breakIrq || edgeIrq;

    // ------------------------------------------------------------------
    // read channel
    // ------------------------------------------------------------------
    assign s_axi_arready = !s_axi_rvalid;

    // one-cycle answer; unmapped words read zero with an error response
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= mapped({s_axi_araddr[4:2], 2'b00}) ? RESP_OKAY : RESP_SLVERR;
            unique case ({s_axi_araddr[4:2], 2'b00})
                OFS_DIV_HIGH: s_axi_rdata <= {24'h0, breakIe_reg, edgeIe_reg, 1'b0,
                                              divHighBuf_reg};
                OFS_DIV_LOW:  s_axi_rdata <= {24'h0, divLow_reg};
                OFS_CTRL:     s_axi_rdata <= {30'h0, rxOn_reg, txOn_reg};
                OFS_SYSOPT:   s_axi_rdata <= {31'h0, posSel_reg};
                OFS_IRQ_STAT: s_axi_rdata <= {30'h0, flags_reg};
                OFS_IRQ_MASK: s_axi_rdata <= {30'h0, irqMask};
                OFS_STATUS:   s_axi_rdata <= {15'h0, baudLink.run, 3'h0, divisor};
                default:      s_axi_rdata <= 32'h0000_0000;
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    // cycles since the last bit tick, for the period check
    logic [16:0] gapCount_reg;
    logic        gapValid_reg;
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            gapCount_reg <= 17'h00000;
            gapValid_reg <= 1'b0;
        end else if (!baudLink.run || $changed(divisor)) begin
            gapCount_reg <= 17'h00000;
            gapValid_reg <= 1'b0;
        end else if (bitTick) begin
            gapCount_reg <= 17'h00001;
            gapValid_reg <= 1'b1;
        end else begin
            gapCount_reg <= gapCount_reg + 17'h00001;
        end
    end

    sequence lowWrite;
        doWrite && wStrb_reg[0] && awAddr_reg == OFS_DIV_LOW;
    endsequence
    sequence highWrite;
        doWrite && wStrb_reg[0] && awAddr_reg == OFS_DIV_HIGH;
    endsequence

    a_tx_pin_route: assert property (
        $past(reset_n) |-> (txPinAltOe == $past(posSel_reg)) && (txPinDefaultOe != txPinAltOe))
        else $error("tx pin enable does not follow position select");
    a_high_buffered: assert property (
        highWrite |=> $stable(divHighWork_reg)
        && divHighBuf_reg == $past(wData_reg[DIV_HIGH_BITS-1:0]))
        else $error("working high half changed without a low write");
    a_low_commits: assert property (
        lowWrite |=> divHighWork_reg == $past(divHighBuf_reg))
        else $error("low write did not commit the buffered high half");
    a_idle_unarmed: assert property (
        !armed_reg |-> !baudLink.run ##1 !baudTick16)
        else $error("generator ran before first enable");
    a_zero_stops: assert property (
        divisor == 13'h0000 |-> !baudLink.run ##1 !baudTick16)
        else $error("generator active with zero divisor");
    a_bit_period: assert property (
        bitTick && gapValid_reg && $stable(divisor)
        |-> gapCount_reg == {divisor, 4'h0})
        else $error("bit period is not sixteen times the divisor");
    a_break_irq: assert property (
        highWrite |=> breakIe_reg == $past(wData_reg[BIT_BREAK_IE]))
        else $error("break enable not taken from high register bit seven");
    a_edge_irq: assert property (
        highWrite |=> edgeIe_reg == $past(wData_reg[BIT_EDGE_IE]))
        else $error("edge enable not taken from high register bit six");
    a_field_place: assert property (
        lowWrite |=> divisor[7:0] == $past(wData_reg[7:0]))
        else $error("low divisor bits misplaced");
    a_bit5_zero: assert property (
        s_axi_rvalid && $rose(s_axi_rvalid) && $past(s_axi_araddr[4:2]) == 3'h0
        |-> !s_axi_rdata[5])
        else $error("high register bit five read back as one");
    a_event_wins: assert property (
        breakDetectEvent && breakIe_reg |=> breakIrq && irq)
        else $error("break event lost or not requested");

endmodule : baud_rate_block

// ===== tb/serial_node.sv
// serial_node: remote serial node wired to both port pin pairs.
// assumes one clock; it echoes whatever pair is driven back onto rx.
`timescale 1ns/1ps
module serial_node (
    // clock
    input  wire logic sys_clk,
    // port pins from the block
    input  wire logic txPinDefault,
    input  wire logic txPinDefaultOe,
    input  wire logic txPinAlt,
    input  wire logic txPinAltOe,
    // port pins toward the block
    output logic      rxPinDefault,
    output logic      rxPinAlt
);
    // a released pair echoes the inverse, so a wrong route never matches
    // echo selected pair
    always_ff @(posedge sys_clk) begin
        rxPinDefault <= txPinDefaultOe ? txPinDefault : !txPinDefault;
        rxPinAlt     <= txPinAltOe ? txPinAlt : !txPinAlt;
    end
endmodule : serial_node

// ===== tb/baud_rate_block_tb.sv
// baud_rate_block_tb: register, timing, interrupt and pin routing checks.
// assumes the serial_node model on the pins and a 10 MHz sys_clk.
`timescale 1ns/1ps
module baud_rate_block_tb;
    import baud_pkg::*;
    logic sys_clk = 0, reset_n = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0, breakDetectEvent = 0, rxEdgeEvent = 0;
    logic secondTxData = 1, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, secondRxData, txPinDefault, txPinDefaultOe, txPinAlt, txPinAltOe;
    logic rxPinDefault, rxPinAlt, baudTick16, bitTick, generatorActive, breakIrq, edgeIrq, irq;
    logic [31:0] s_axi_awaddr = 0, s_axi_wdata = 0, s_axi_araddr = 0, s_axi_rdata;
    logic [3:0]  s_axi_wstrb  = 4'hF;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [33:0] expQ[$];
    logic [16:0] rnd = 17'h10687;
    int          errCount = 0, nTests = 0, n, d;
    localparam int LIM = 20000; // the longest tick period is 8191 cycles
    baud_rate_block DUT (.*);
    serial_node node (.sys_clk, .txPinDefault, .txPinDefaultOe, .txPinAlt, .txPinAltOe,
                      .rxPinDefault, .rxPinAlt);
    initial forever #50 sys_clk = ~sys_clk;
    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    function logic [16:0] lfsr(input logic [16:0] s);
        return {s[15:0], s[16] ^ s[13]};
    endfunction : lfsr
    task results;
        $display("compares %0d mismatches %0d", nTests, errCount);
        if (errCount == 0 && nTests > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : results
    task chk(input logic [33:0] s, input logic [33:0] e);
        nTests++;
        if (s !== e) begin
            errCount++;
            $display("[ERR] %0t seen %h expected %h", $time, s, e);
        end
    endtask : chk
    task hang(input int k);
        if (k >= LIM) begin
            errCount++;
            results();
        end
    endtask : hang
    // write: both halves offered together, each dropped once taken
    task wr(input logic [31:0] a, input logic [31:0] v, input logic [1:0] r = RESP_OKAY);
        int k;
        @(posedge sys_clk);
        expQ.push_back({r, 32'h0});
        s_axi_awaddr <= a; s_axi_wdata <= v;
        s_axi_awvalid <= 1; s_axi_wvalid <= 1; s_axi_bready <= 1;
        for (k = 0; k < LIM; k++) begin
            @(posedge sys_clk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 0;
            if (s_axi_bvalid) break;
        end
        hang(k);
        s_axi_bready <= 0;
    endtask : wr
    task rd(input logic [31:0] a, input logic [31:0] v, input logic [1:0] r = RESP_OKAY);
        int k;
        @(posedge sys_clk);
        expQ.push_back({r, v});
        s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1;
        for (k = 0; k < LIM; k++) begin
            @(posedge sys_clk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 0;
            if (s_axi_rvalid) break;
        end
        hang(k);
        s_axi_rready <= 0;
    endtask : rd
    // cycles between two ticks of the chosen kind
    task per(input bit b, output int c);
        int k;
        for (k = 0; k < LIM && (b ? bitTick : baudTick16) !== 1; k++) @(posedge sys_clk);
        hang(k);
        c = 0;
        do begin
            @(posedge sys_clk);
            c++;
        end while ((b ? bitTick : baudTick16) !== 1 && c < LIM);
        hang(c);
    endtask : per
    task pulse(input int i);
        @(posedge sys_clk);
        if (i) rxEdgeEvent <= 1; else breakDetectEvent <= 1;
        @(posedge sys_clk);
        rxEdgeEvent <= 0; breakDetectEvent <= 0;
    endtask : pulse
    // bus responses are compared against the oldest noted expectation
    always @(posedge sys_clk) begin
        if (s_axi_bvalid && s_axi_bready) chk({s_axi_bresp, 32'h0}, expQ.pop_front());
        if (s_axi_rvalid && s_axi_rready) chk({s_axi_rresp, s_axi_rdata}, expQ.pop_front());
    end
    initial begin
        repeat (100000) @(posedge sys_clk);
        errCount++;
        results();
    end
    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (16) @(posedge sys_clk);
        reset_n <= 1;
        rd(32'h18, 32'h0000_0004);
        chk(generatorActive, 0);
        wr(32'h00, 32'h3F);
        rd(32'h00, 32'h1F);
        rd(32'h18, 32'h0000_0004);
        wr(32'h04, 32'h03);
        rd(32'h18, 32'h0000_1F03);
        wr(32'h08, 32'h01);
        chk(generatorActive, 1);
        for (int j = 0; j < 4; j++) begin
            rnd = lfsr(rnd);
            d = (j == 0) ? 1 : (j == 3) ? 8191 : 2 + rnd % 6;
            wr(32'h00, d >> 8);
            wr(32'h04, d & 8'hFF);
            rd(32'h18, 32'h0001_0000 | d);
            per(0, n);
            chk(n, d);
            if (j < 3) per(1, n);
            if (j < 3) chk(n, 16 * d);
        end
        wr(32'h00, 32'h00);
        wr(32'h04, 32'h00);
        chk(generatorActive, 0);
        n = 0;
        repeat (60) @(posedge sys_clk) n += baudTick16 | bitTick;
        chk(n, 0);
        for (int i = 0; i < 2; i++) begin
            pulse(i);
            @(posedge sys_clk);
            chk(irq, 0);
            rd(32'h10, 1 << i);
            wr(32'h00, i ? 32'h40 : 32'h80);
            chk({irq, i ? edgeIrq : breakIrq}, 2'b11);
            wr(32'h14, 0);
            chk(irq, 0);
            wr(32'h14, 1 << i);
            wr(32'h10, 1 << i);
            chk({breakIrq, edgeIrq, irq}, 0);
        end
        wr(32'h14, 32'h3);
        rd(32'h14, 32'h3);
        pulse(0);
        @(posedge sys_clk);
        chk({breakIrq, irq}, 2'b11);
        for (int p = 0; p < 2; p++) begin
            wr(32'h0C, p);
            repeat (4) begin
                rnd = lfsr(rnd);
                secondTxData <= rnd[0];
                repeat (8) @(posedge sys_clk);
                chk({txPinAltOe, txPinDefaultOe}, p ? 2 : 1);
                chk({p ? txPinAlt : txPinDefault, secondRxData}, {2{rnd[0]}});
            end
        end
        wr(32'h1C, 32'hFF, RESP_SLVERR);
        rd(32'h1C, 32'h0, RESP_SLVERR);
        repeat (2) @(posedge sys_clk);
        results();
    end
endmodule : baud_rate_block_tb
